//--- sac_clk_div.sv
// converter clock tick generator with selectable divider
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_clk_div
   import sac_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [1:0] divSel,
   output logic tick
);
   logic [7:0] count_ff;
   logic [7:0] limit;

   // terminal count per divider code; code 11 falls back to the slowest rate
   always_comb begin
      case (divSel)
         `SAC_DIV_FAST: limit = 8'(`SAC_DIV_CYC(`SAC_ADC_HZ_FAST) - 1);
         `SAC_DIV_MID: limit = 8'(`SAC_DIV_CYC(`SAC_ADC_HZ_MID) - 1);
         default: limit = 8'(`SAC_DIV_CYC(`SAC_ADC_HZ_SLOW) - 1);
      endcase
   end

   // free count while running, held at zero otherwise
   always_ff @(posedge core_clk) begin
      if (!resetn || !run || count_ff >= limit) begin
         count_ff <= 8'h00;
      end else begin
         count_ff <= count_ff + 8'h01;
      end
   end

   assign tick = run && (count_ff >= limit);
endmodule
`default_nettype wire

//--- sac_converter_ctrl.sv
// converter control top: APB registers, conversion sequencing, result lock
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_converter_ctrl
   import sac_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic haltMode,
   input wire logic waitMode,
   input wire logic compIn,
   output logic anaPowerOn,
   output logic sampleEn,
   output logic [3:0] chanSel,
   output logic [9:0] dacCode,
   output logic convIrq,
   output logic wakeReq
);
   // software fields
   logic [1:0] clockDividerSelect_ff;
   logic converterOn_ff;
   logic [3:0] channel_ff;
   logic convIrqEnable_ff;
   logic eoc_ff;
   logic lock_ff;
   logic [9:0] resultReg_ff;
   logic [31:0] prdata_ff;

   // reset images, so single fields can be picked out of them
   localparam logic [7:0] rstCsrImg = `SAC_RST_CSR;
   localparam logic [7:0] rstHighImg = `SAC_RST_HIGH;
   localparam logic [7:0] rstLowImg = `SAC_RST_LOW;
   localparam logic [7:0] rstAuxImg = `SAC_RST_AUX;

   // sequencing
   sac_state_e state_ff;
   sac_state_e nxt_state;
   logic [1:0] sampleCnt_ff;
   logic [15:0] stabCnt_ff;
   logic stabNeed_ff;

   // bus decode
   logic access;
   logic wrAcc;
   logic rdAcc;
   logic hitCsr;
   logic hitHigh;
   logic hitLow;
   logic hitAux;
   logic hitAny;
   logic csrWr;
   logic auxWr;
   logic highRd;
   logic lowRd;
   logic [7:0] rdByte;

   // converter control
   logic active;
   logic restart;
   logic tick;
   logic sarStart;
   logic sarStep;
   logic sarDone;
   logic [9:0] sarResult;
   logic [3:0] newChan;
   logic newOn;

   // address decode of the four word registers
   always_comb begin
      hitCsr = (paddr == sac_byte_addr(`SAC_IDX_CSR));
      hitHigh = (paddr == sac_byte_addr(`SAC_IDX_HIGH));
      hitLow = (paddr == sac_byte_addr(`SAC_IDX_LOW));
      hitAux = (paddr == sac_byte_addr(`SAC_IDX_AUX));
      hitAny = hitCsr || hitHigh || hitLow || hitAux;
   end

   // zero-wait slave: access phase completes at once, unmapped answers an error
   assign access = psel && penable;
   assign wrAcc = access && pwrite;
   assign rdAcc = access && !pwrite;
   assign pready = 1'b1;
   assign pslverr = access && !hitAny;

   assign csrWr = wrAcc && hitCsr;
   assign auxWr = wrAcc && hitAux;
   assign highRd = rdAcc && hitHigh;
   assign lowRd = rdAcc && hitLow;

   // values software would write into control fields
   assign newChan = pwdata[`SAC_CH_HI:`SAC_CH_LO];
   assign newOn = pwdata[`SAC_ON_BIT];

   // read data byte for the addressed register, reserved bits zero
   always_comb begin
      rdByte = 8'h00;
      if (hitCsr) begin
         rdByte[`SAC_EOC_BIT] = eoc_ff;
         rdByte[`SAC_DIV_HI:`SAC_DIV_LO] = clockDividerSelect_ff;
         rdByte[`SAC_ON_BIT] = converterOn_ff;
         rdByte[`SAC_CH_HI:`SAC_CH_LO] = channel_ff;
      end else if (hitHigh) begin
         rdByte = resultReg_ff[9:2];
      end else if (hitLow) begin
         rdByte = {6'h00, resultReg_ff[1:0]};
      end else if (hitAux) begin
         rdByte[`SAC_IRQEN_BIT] = convIrqEnable_ff;
      end
   end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= {24'h00_0000, rdByte};
      end
   end
   assign prdata = prdata_ff;

   // control fields of converter_control_status
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         clockDividerSelect_ff <= rstCsrImg[`SAC_DIV_HI:`SAC_DIV_LO];
         converterOn_ff <= rstCsrImg[`SAC_ON_BIT];
         channel_ff <= rstCsrImg[`SAC_CH_HI:`SAC_CH_LO];
      end else if (csrWr) begin
         clockDividerSelect_ff <= pwdata[`SAC_DIV_HI:`SAC_DIV_LO];
         converterOn_ff <= newOn;
         channel_ff <= newChan;
      end
   end

   // interrupt enable in the auxiliary clock control register
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         convIrqEnable_ff <= rstAuxImg[`SAC_IRQEN_BIT];
      end else if (auxWr) begin
         convIrqEnable_ff <= pwdata[`SAC_IRQEN_BIT];
      end
   end

   // the converter runs only when switched on and the chip is not halted
   assign active = converterOn_ff && !haltMode;

   // a fresh start: switching on, or a write that changes the channel while switched on
   assign restart = csrWr && newOn &&
      (!converterOn_ff || (newChan != channel_ff));

   // remember a halt so the next start waits for the analog to settle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stabNeed_ff <= 1'b0;
      end else if (haltMode) begin
         stabNeed_ff <= 1'b1;
      end else if (state_ff == SAC_STAB && stabCnt_ff == 16'h0000) begin
         stabNeed_ff <= 1'b0;
      end
   end

   // stabilization countdown, reloaded in every state but settle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stabCnt_ff <= 16'h0000;
      end else if (state_ff != SAC_STAB) begin
         stabCnt_ff <= 16'(`SAC_STAB_CYC - 1);
      end else if (stabCnt_ff != 16'h0000) begin
         stabCnt_ff <= stabCnt_ff - 16'h0001;
      end
   end

   // sequencer: idle, settle (only after a halt), sample, approximate, then sample again
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SAC_IDLE: begin
            if (active) begin
               nxt_state = stabNeed_ff ? SAC_STAB : SAC_SAMPLE;
            end
         end
         SAC_STAB: begin
            if (stabCnt_ff == 16'h0000) begin
               nxt_state = SAC_SAMPLE;
            end
         end
         SAC_SAMPLE: begin
            if (tick && sampleCnt_ff == 2'(`SAC_SAMPLE_TICKS - 1)) begin
               nxt_state = SAC_CONV;
            end
         end
         SAC_CONV: begin
            if (sarDone) begin
               nxt_state = SAC_SAMPLE;
            end
         end
         default: begin
            nxt_state = SAC_IDLE;
         end
      endcase
      if (!active) begin
         nxt_state = SAC_IDLE;
      end else if (restart && state_ff != SAC_IDLE && state_ff != SAC_STAB) begin
         nxt_state = SAC_SAMPLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_ff <= SAC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // sampling period count in converter clock ticks
   always_ff @(posedge core_clk) begin
      if (!resetn || state_ff != SAC_SAMPLE || restart) begin
         sampleCnt_ff <= 2'b00;
      end else if (tick) begin
         sampleCnt_ff <= sampleCnt_ff + 2'b01;
      end
   end

   // the search begins as sampling ends and advances one bit per tick
   assign sarStart = (state_ff == SAC_SAMPLE) && (nxt_state == SAC_CONV);
   assign sarStep = (state_ff == SAC_CONV) && tick && !restart && active;

   sac_clk_div u_clk_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .run(active),
      .divSel(clockDividerSelect_ff),
      .tick(tick)
   );

   sac_sar_step u_sar (
      .core_clk(core_clk),
      .resetn(resetn),
      .start(sarStart),
      .step(sarStep),
      .compIn(compIn),
      .dacCode(dacCode),
      .done(sarDone),
      .result(sarResult)
   );

   // lock set by reading the lower half, released by the upper half or by switching the converter off
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lock_ff <= 1'b0;
      end else if (!converterOn_ff || highRd) begin
         lock_ff <= 1'b0;
      end else if (lowRd) begin
         lock_ff <= 1'b1;
      end
   end

   // result update on completion unless locked with no same-cycle upper read, or being locked now
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         resultReg_ff <= {rstHighImg, rstLowImg[1:0]};
      end else if (sarDone && state_ff == SAC_CONV && !(lock_ff && !highRd) && !lowRd) begin
         resultReg_ff <= sarResult;
      end
   end

   // completion flag: completion wins over a same-cycle read of the upper half
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         eoc_ff <= rstCsrImg[`SAC_EOC_BIT];
      end else if (sarDone && state_ff == SAC_CONV) begin
         eoc_ff <= 1'b1;
      end else if (highRd) begin
         eoc_ff <= 1'b0;
      end else if (restart || !converterOn_ff) begin
         eoc_ff <= 1'b0;
      end
   end

   // analog-side controls
   assign anaPowerOn = active;
   assign sampleEn = (state_ff == SAC_SAMPLE);
   assign chanSel = channel_ff;

   // interrupt request; it may wake the core from wait but never from halt
   assign convIrq = eoc_ff && convIrqEnable_ff;
   assign wakeReq = convIrq && waitMode && !haltMode;
endmodule
`default_nettype wire

//--- sac_converter_ctrl_assertions.sv
// port-level checks for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_converter_ctrl_assertions
   import sac_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic haltMode,
   input wire logic waitMode,
   input wire logic compIn,
   input wire logic anaPowerOn,
   input wire logic sampleEn,
   input wire logic [3:0] chanSel,
   input wire logic [9:0] dacCode,
   input wire logic convIrq,
   input wire logic wakeReq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // access phase, and a write to control/status in it
   sequence acc_s;
      psel && penable;
   endsequence
   sequence csr_wr_s;
      acc_s ##0 pwrite && paddr == 12'hB8;
   endsequence
   hole_err_a: assert property (
      acc_s ##0 !(paddr inside {12'hB8, 12'hBC, 12'hC0, 12'hC4}) |-> pslverr)
      else $error("unmapped access not refused");
   low_pad_a: assert property (
      acc_s ##0 !pwrite && paddr == 12'hC0 |-> prdata[31:2] == 30'h0)
      else $error("low result padding not zero");
   on_bit_a: assert property (
      csr_wr_s |=> haltMode || anaPowerOn == $past(pwdata[4]))
      else $error("power does not follow the on bit");
   chan_field_a: assert property (csr_wr_s |=> chanSel == $past(pwdata[3:0]))
      else $error("input select does not follow the write");
   wake_gate_a: assert property (wakeReq |-> convIrq && waitMode && !haltMode)
      else $error("wake request without cause");
   halt_off_a: assert property (haltMode [*2] |-> !anaPowerOn && !sampleEn)
      else $error("converter active in halt");
   off_quiet_a: assert property (csr_wr_s ##0 !pwdata[4] |=> ##1 !convIrq [*7])
      else $error("completion seen after turning off");
   restart_a: assert property (
      csr_wr_s ##0 (pwdata[4] && anaPowerOn && !haltMode && pwdata[3:0] != chanSel)
      |-> ##[1:3] sampleEn) else $error("no restart");
endmodule
bind sac_converter_ctrl sac_converter_ctrl_assertions i_chk (
   .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .haltMode, .waitMode, .compIn, .anaPowerOn, .sampleEn, .chanSel,
   .dacCode, .convIrq, .wakeReq
);
`default_nettype wire

//--- sac_converter_ctrl_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_converter_ctrl_tb_top
   import sac_pkg::*;
;
   localparam logic [11:0] CSR = 12'hB8;
   localparam logic [11:0] HI = 12'hBC;
   localparam logic [11:0] LO = 12'hC0;
   localparam logic [11:0] AUX = 12'hC4;
   logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic haltMode = 1'b0, waitMode = 1'b0, compIn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, anaPowerOn, sampleEn, convIrq, wakeReq;
   logic [3:0] chanSel;
   logic [9:0] dacCode;
   logic [9:0] ain [16] = '{default: 10'h000};
   logic [11:0] regA [4] = '{CSR, HI, LO, AUX};
   int per [4] = '{63, 125, 250, 250};
   logic [31:0] rd;
   logic errSeen;
   int n;
   int fails = 0;
   int samplesChecked = 0;

   sac_converter_ctrl i_dut (
      .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .haltMode, .waitMode, .compIn, .anaPowerOn, .sampleEn, .chanSel,
      .dacCode, .convIrq, .wakeReq
   );

   // core clock, 4 ns period
   always #2 core_clk = ~core_clk;

   // comparator stand-in: selected input against the trial code
   always @(posedge core_clk) begin
      compIn <= ain[chanSel] >= dacCode;
   end

   // verdict and end of run
   task automatic summarize();
      $display("compares %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // a wait that ran out ends the run
   task automatic timedOut();
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      summarize();
   endtask

   // compares a seen value with the expected one
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one transfer: setup, access until ready, then release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      // access phase: ready and data are taken at the edge that ends it
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      errSeen = pslverr;
      if (pready !== 1'b1) begin
         timedOut();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // polls the completion flag, counting cycles in n
   task automatic waitEoc();
      n = 0;
      do begin
         apb(1'b0, CSR, 8'h00);
         n += 3;
      end while (rd[7] !== 1'b1 && n < 6000);
      if (n >= 6000) begin
         timedOut();
      end
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      foreach (regA[i]) begin
         apb(1'b0, regA[i], 8'h00);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'hC8, 8'h00);
      chk(32'(errSeen), 32'h1);
      // first sample on input 3, fastest divider
      ain[3] = 10'h2B5;
      apb(1'b1, CSR, 8'h13);
      waitEoc();
      chk(rd, 32'h93);
      apb(1'b0, LO, 8'h00);
      chk(rd, 32'h1);
      apb(1'b0, HI, 8'h00);
      chk(rd, 32'hAD);
      apb(1'b0, CSR, 8'h00);
      chk(rd, 32'h13);
      // lower read holds the pair over a later completion
      apb(1'b0, LO, 8'h00);
      ain[3] = 10'h3FF;
      apb(1'b1, HI, 8'h55);
      waitEoc();
      apb(1'b0, HI, 8'h00);
      chk(rd, 32'hAD);
      waitEoc();
      apb(1'b0, LO, 8'h00);
      chk(rd, 32'h3);
      apb(1'b0, HI, 8'h00);
      chk(rd, 32'hFF);
      // input change in mid conversion restarts on the new input
      ain[9] = 10'h155;
      repeat (300) @(posedge core_clk);
      apb(1'b1, CSR, 8'h19);
      waitEoc();
      chk(32'(n > 756 && n <= 888), 32'h1);
      apb(1'b0, HI, 8'h00);
      chk(rd, 32'h55);
      // every divider code, timed from a fresh start
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, CSR, 8'h00);
         apb(1'b1, CSR, {1'b0, d[1:0], 5'h19});
         waitEoc();
         chk(32'(n > 12 * per[d] && n <= 14 * per[d] + 6), 32'h1);
         apb(1'b0, HI, 8'h00);
         chk(rd, 32'h55);
      end
      // interrupt seen as a wake request, cleared, then masked
      apb(1'b1, AUX, 8'h01);
      waitMode <= 1'b1;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (convIrq !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         timedOut();
      end
      chk(32'(wakeReq), 32'h1);
      @(posedge core_clk);
      apb(1'b0, HI, 8'h00);
      @(negedge core_clk);
      chk(32'(convIrq), 32'h0);
      @(posedge core_clk);
      apb(1'b1, AUX, 8'h00);
      waitEoc();
      chk(32'(convIrq), 32'h0);
      // turning off releases the lock and stops conversions
      apb(1'b0, LO, 8'h00);
      apb(1'b1, CSR, 8'h09);
      @(negedge core_clk);
      chk(32'(anaPowerOn), 32'h0);
      repeat (1000) @(posedge core_clk);
      apb(1'b0, CSR, 8'h00);
      chk(rd, 32'h09);
      ain[9] = 10'h100;
      apb(1'b1, CSR, 8'h19);
      waitEoc();
      apb(1'b0, HI, 8'h00);
      chk(rd, 32'h40);
      // halt stops the converter; restart waits for settling
      haltMode <= 1'b1;
      @(negedge core_clk);
      chk(32'(anaPowerOn), 32'h0);
      repeat (300) @(posedge core_clk);
      haltMode <= 1'b0;
      waitEoc();
      chk(32'(n > 1006 && n <= 1138), 32'h1);
      summarize();
   end
endmodule
`default_nettype wire

//--- sac_params.svh
// constants for the converter control block: offsets, fields, resets, timing
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// register indexes; byte address is four times the index
`define SAC_IDX_CSR 8'h2E
`define SAC_IDX_HIGH 8'h2F
`define SAC_IDX_LOW 8'h30
`define SAC_IDX_AUX 8'h31

// register reset values
`define SAC_RST_CSR 8'h00
`define SAC_RST_HIGH 8'h00
`define SAC_RST_LOW 8'h00
`define SAC_RST_AUX 8'h00

// field positions in converter_control_status and clock_control_aux_reg
`define SAC_EOC_BIT 7
`define SAC_DIV_HI 6
`define SAC_DIV_LO 5
`define SAC_ON_BIT 4
`define SAC_CH_HI 3
`define SAC_CH_LO 0
`define SAC_IRQEN_BIT 0

// clock_divider_select codes
`define SAC_DIV_FAST 2'b00
`define SAC_DIV_MID 2'b01
`define SAC_DIV_SLOW 2'b10

// clock rates in Hz and MHz
`define SAC_CORE_HZ 250000000
`define SAC_CORE_MHZ 250
`define SAC_ADC_HZ_FAST 4000000
`define SAC_ADC_HZ_MID 2000000
`define SAC_ADC_HZ_SLOW 1000000

// converter clock period in core cycles, rounded up so the rate never exceeds the figure
`define SAC_DIV_CYC(f) ((`SAC_CORE_HZ + (f) - 1) / (f))

// stabilization after halt, in ns, and in core cycles rounded up
`define SAC_STAB_NS 1000
`define SAC_STAB_CYC ((`SAC_STAB_NS * `SAC_CORE_MHZ + 999) / 1000)

// conversion shape in converter clock ticks
`define SAC_SAMPLE_TICKS 3
`define SAC_SAR_MSB 10'h200

`endif

//--- sac_pkg.sv
// types and helpers shared by the converter control block
`include "sac_params.svh"
package sac_pkg;
   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_STAB = 2'b01,
      SAC_SAMPLE = 2'b11,
      SAC_CONV = 2'b10
   } sac_state_e;

   // byte address of a register index
   function automatic logic [11:0] sac_byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
endpackage

//--- sac_sar_step.sv
// successive-approximation bit search over ten result bits
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_sar_step
   import sac_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic step,
   input wire logic compIn,
   output logic [9:0] dacCode,
   output logic done,
   output logic [9:0] result
);
   logic [9:0] trial_ff;
   logic [9:0] mask_ff;
   logic busy_ff;
   logic done_ff;
   logic [9:0] result_ff;
   logic [9:0] kept;

   // comparator high keeps the trial bit, low drops it
   assign kept = compIn ? trial_ff : (trial_ff & ~mask_ff);

   // trial code and bit pointer; start restarts any search in flight
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         trial_ff <= 10'h000;
         mask_ff <= 10'h000;
         busy_ff <= 1'b0;
      end else if (start) begin
         trial_ff <= `SAC_SAR_MSB;
         mask_ff <= `SAC_SAR_MSB;
         busy_ff <= 1'b1;
      end else if (step && busy_ff) begin
         trial_ff <= mask_ff[0] ? kept : (kept | (mask_ff >> 1));
         mask_ff <= mask_ff >> 1;
         busy_ff <= !mask_ff[0];
      end
   end

   // final code and one-cycle completion pulse; saturation falls out as 3FF or 000
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         done_ff <= 1'b0;
         result_ff <= 10'h000;
      end else begin
         done_ff <= step && busy_ff && mask_ff[0] && !start;
         if (step && busy_ff && mask_ff[0] && !start) begin
            result_ff <= kept;
         end
      end
   end

   assign dacCode = trial_ff;
   assign done = done_ff;
   assign result = result_ff;
endmodule
`default_nettype wire
